// ===== bspm_map.vh
`ifndef BSPM_MAP_VH
`define BSPM_MAP_VH
`define SYNC_CTRL 2'b10
`define BT_LOCAL_FAULT 8'h4b
`define LF_PAYLOAD 56'h00000001000000
`define BT_ERR_CTRL 8'h1e
`define ERR_CTRL_PAYLOAD 56'h3c78f1e3c78f1e
`define SIGMA_NUM 15'h0d2d
`define SIGMA_DEN 15'h5b58
`define CNT_LOW 14'h03b4
`define CNT_HIGH 14'h03b5
`define BLK_PER_FRAME 10'h3b8
`define STUFF_L0 10'h001
`define STUFF_L1 10'h0ef
`define STUFF_L2 10'h1dd
`define STUFF_L3 10'h2cb
`define STUFF_H1 10'h13e
`define STUFF_H2 10'h27b
`define PH_OH 2'h0
`define PH_PAD 2'h1
`define PH_CAL 2'h2
`define SLOTS_FULL 5'h14
`define SUBCAL_LEN 10'h3ff
`define SH_POS 3'h1
`endif

// ===== block_stream_payload_mapper.v
`timescale 1ns/10ps
`default_nettype none
`include "bspm_map.vh"
// Summary of operation
// - scramble before insertion, descramble after demapping
// - self-synchronizing scrambler 1+x^39+x^58
// - sync header bypasses the scrambler
// - idle insert/delete done by client rate adapter
// - rates fixed by clocking, not logic
// - overhead holds type code and client fail
// - blocks aligned on odd bit positions
// - client fail substitutes local-fault blocks
// - unit fail yields local-fault blocks out
// - local-fault block is 10, 4B, lane3 01
// - carries p instances, 1024*n block frames
// - slot counts 20 or 0/5/10/15 negotiated
// - drop unavailable slots, reinsert on demap
// - insert n_i-1 padding error-control blocks
// - overhead, padding, calendar in instance order
// - error-control block is 10, 1E, all 1E
// - unequipped trailing instances not carried
// - FlexE-aware rates fixed by clocking
// - 16-byte stuffing via 15-bit sigma-delta
// - deterministic count, per-unit equals per-frame
// - count 948 below 3373 else 949
// - frame index runs 1 to 23384
// - stuff block positions per count, zeros
// - justification bytes: count, II, DI, CRC-8
module block_stream_payload_mapper #(
  parameter MAXP = 4
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_sync_rst,
  input wire i_flexe_aware,
  input wire i_client_fail,
  input wire i_unit_fail,
  input wire [7:0] i_payload_type_code,
  input wire [7:0] i_num_inst,
  input wire [5*MAXP-1:0] i_slot_cnt,
  input wire [MAXP-1:0] i_inst_equipped,
  input wire i_tx_valid,
  input wire [65:0] i_tx_block,
  input wire [MAXP-1:0] i_tx_inst_sel,
  input wire i_tx_is_oh,
  input wire i_tx_unavail,
  input wire i_frame_start,
  input wire [9:0] i_blk16_idx,
  input wire i_rx_valid,
  input wire [65:0] i_rx_block,
  input wire i_rx_unavail_slot,
  output wire o_tx_ready,
  output reg o_tx_valid_ff,
  output reg [65:0] o_tx_block_ff,
  output wire o_stuff_blk,
  output wire [127:0] o_stuff_data,
  output reg [13:0] o_count_ff,
  output wire [23:0] o_justification_control_bytes,
  output wire [7:0] o_payload_structure_id,
  output wire o_client_fail_indicator,
  output reg o_rx_valid_ff,
  output reg [65:0] o_rx_block_ff,
  output wire [2:0] o_sh_bit_pos
);
  localparam [65:0] LF_BLK = {`LF_PAYLOAD, `BT_LOCAL_FAULT, `SYNC_CTRL};
  localparam [65:0] EC_BLK = {`ERR_CTRL_PAYLOAD, `BT_ERR_CTRL, `SYNC_CTRL};
  // two-flop synchronisers for the fail pins
  reg csync1_ff;
  reg csync2_ff;
  reg usync1_ff;
  reg usync2_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      csync1_ff <= 1'b0;
      csync2_ff <= 1'b0;
      usync1_ff <= 1'b0;
      usync2_ff <= 1'b0;
    end else begin
      csync1_ff <= i_client_fail;
      csync2_ff <= csync1_ff;
      usync1_ff <= i_unit_fail;
      usync2_ff <= usync1_ff;
    end
  end
  // padding count per instance and equipment gate
  localparam [1:0] ST_OH = `PH_OH;
  localparam [1:0] ST_PAD = `PH_PAD;
  localparam [1:0] ST_CAL = `PH_CAL;
  reg [1:0] phase_ff;
  reg [7:0] inst_ff;
  reg [4:0] pad_ff;
  reg [7:0] last_inst;
  integer k;
  always @* begin
    last_inst = 8'h00;
    for (k = 0; k < MAXP; k = k + 1) begin
      if (i_inst_equipped[k] && (k < i_num_inst)) begin
        last_inst = k[7:0];
      end
    end
  end
  wire [4:0] cur_slots = i_slot_cnt[inst_ff[1:0]*5 +: 5];
  wire pad_phase = i_flexe_aware && (phase_ff == ST_PAD);
  wire pad_emit = pad_phase && (pad_ff + 5'h01 < cur_slots);
  wire drop_blk = i_flexe_aware && i_tx_unavail;
  // source stalls for the whole padding phase
  assign o_tx_ready = !pad_phase;
  // group walk: overheads, padding, then calendar
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_ff <= ST_OH;
      inst_ff <= 8'h00;
      pad_ff <= 5'h00;
    end else if (!i_flexe_aware) begin
      phase_ff <= ST_OH;
      inst_ff <= 8'h00;
      pad_ff <= 5'h00;
    end else begin
      case (phase_ff)
        ST_OH: begin
          if (i_tx_valid && i_tx_is_oh) begin
            if (inst_ff >= last_inst) begin
              phase_ff <= ST_PAD;
              inst_ff <= 8'h00;
            end else begin
              inst_ff <= inst_ff + 8'h01;
            end
          end
        end
        ST_PAD: begin
          if (pad_emit) begin
            pad_ff <= pad_ff + 5'h01;
          end else if (inst_ff >= last_inst) begin
            phase_ff <= ST_CAL;
            inst_ff <= 8'h00;
            pad_ff <= 5'h00;
          end else begin
            inst_ff <= inst_ff + 8'h01;
            pad_ff <= 5'h00;
          end
        end
        ST_CAL: begin
          // next group's first overhead block counts for instance 0
          if (i_tx_valid && i_tx_is_oh) begin
            if (last_inst == 8'h00) begin
              phase_ff <= ST_PAD;
              inst_ff <= 8'h00;
            end else begin
              phase_ff <= ST_OH;
              inst_ff <= 8'h01;
            end
          end
        end
        default: begin
          phase_ff <= ST_OH;
          inst_ff <= 8'h00;
          pad_ff <= 5'h00;
        end
      endcase
    end
  end
  // source select: padding, fault, client
  reg [65:0] tx_src;
  reg tx_src_v;
  always @* begin
    tx_src = i_tx_block;
    // a stalled source must not slip a block through
    tx_src_v = i_tx_valid && o_tx_ready && !drop_blk;
    if (pad_emit) begin
      tx_src = EC_BLK;
      tx_src_v = 1'b1;
    end else if (csync2_ff) begin
      tx_src = LF_BLK;
      tx_src_v = 1'b1;
    end
  end
  // self-synchronizing scrambler, one block per cycle
  reg [57:0] tx_scr_ff;
  reg [57:0] rx_scr_ff;
  reg [63:0] scr_out;
  reg [121:0] scr_ext;
  reg [63:0] dsc_out;
  reg [121:0] dsc_ext;
  integer b;
  always @* begin
    scr_ext = {64'h0, tx_scr_ff};
    scr_out = 64'h0;
    for (b = 0; b < 64; b = b + 1) begin
      scr_out[b] = tx_src[b+2] ^ scr_ext[b+19] ^ scr_ext[b];
      scr_ext[b+58] = scr_out[b];
    end
    dsc_ext = {i_rx_block[65:2], rx_scr_ff};
    dsc_out = 64'h0;
    for (b = 0; b < 64; b = b + 1) begin
      dsc_out[b] = dsc_ext[b+58] ^ dsc_ext[b+19] ^ dsc_ext[b];
    end
  end
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_scr_ff <= 58'h0;
      rx_scr_ff <= 58'h0;
      o_tx_valid_ff <= 1'b0;
      o_tx_block_ff <= 66'h0;
      o_rx_valid_ff <= 1'b0;
      o_rx_block_ff <= 66'h0;
    end else if (i_sync_rst) begin
      tx_scr_ff <= 58'h0;
      rx_scr_ff <= 58'h0;
      o_tx_valid_ff <= 1'b0;
      o_rx_valid_ff <= 1'b0;
    end else begin
      o_tx_valid_ff <= tx_src_v;
      if (tx_src_v) begin
        tx_scr_ff <= scr_ext[121:64];
        o_tx_block_ff <= {scr_out, tx_src[1:0]};
      end
      o_rx_valid_ff <= i_rx_valid || usync2_ff;
      if (usync2_ff) begin
        o_rx_block_ff <= LF_BLK;
      end else if (i_rx_valid) begin
        rx_scr_ff <= i_rx_block[65:8];
        if (i_flexe_aware && i_rx_unavail_slot) begin
          o_rx_block_ff <= EC_BLK;
        end else begin
          o_rx_block_ff <= {dsc_out, i_rx_block[1:0]};
        end
      end
    end
  end
  // sigma-delta frame count
  // accumulator holds (j*num) mod den after frame j
  reg [14:0] acc_ff;
  wire [15:0] acc_sum = {1'b0, acc_ff} + {1'b0, `SIGMA_NUM};
  wire [14:0] acc_nxt = (acc_sum >= {1'b0, `SIGMA_DEN}) ?
    acc_sum[14:0] - `SIGMA_DEN : acc_sum[14:0];
  wire [13:0] cnt_nxt = (acc_nxt < `SIGMA_NUM) ? `CNT_LOW : `CNT_HIGH;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_ff <= 15'h0;
      o_count_ff <= `CNT_HIGH;
    end else if (i_sync_rst) begin
      acc_ff <= 15'h0;
      o_count_ff <= `CNT_HIGH;
    end else if (i_frame_start) begin
      acc_ff <= acc_nxt;
      o_count_ff <= cnt_nxt;
    end
  end
  // stuffed 16-byte block positions per count
  reg stuff_hit;
  always @* begin
    stuff_hit = (i_blk16_idx == `STUFF_L0);
    case (o_count_ff)
      `CNT_LOW: begin
        if (i_blk16_idx == `STUFF_L1 || i_blk16_idx == `STUFF_L2 ||
          i_blk16_idx == `STUFF_L3) begin
          stuff_hit = 1'b1;
        end
      end
      `CNT_HIGH: begin
        if (i_blk16_idx == `STUFF_H1 || i_blk16_idx == `STUFF_H2) begin
          stuff_hit = 1'b1;
        end
      end
      default: begin
        stuff_hit = 1'b0;
      end
    endcase
  end
  assign o_stuff_blk = i_flexe_aware && stuff_hit;
  assign o_stuff_data = 128'h0;
  // crc-8 over count and indicators, poly x^8+x^2+x+1
  wire jc_inc = 1'b0;
  wire jc_dec = 1'b0;
  reg [7:0] crc;
  reg [15:0] jc_bits;
  integer c;
  always @* begin
    jc_bits = {o_count_ff, jc_inc, jc_dec};
    crc = 8'h00;
    for (c = 15; c >= 0; c = c - 1) begin
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ jc_bits[c]) ? 8'h07 : 8'h00);
    end
  end
  // overhead fields registered like the data path
  reg [7:0] psi_ff;
  reg csf_ff;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      psi_ff <= 8'h00;
      csf_ff <= 1'b0;
    end else begin
      psi_ff <= i_payload_type_code;
      csf_ff <= csync2_ff;
    end
  end
  assign o_justification_control_bytes = {jc_bits, crc};
  assign o_payload_structure_id = psi_ff;
  assign o_client_fail_indicator = csf_ff;
  assign o_sh_bit_pos = `SH_POS;
endmodule
`default_nettype wire

// ===== bspm_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module bspm_chk (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_flexe_aware,
  input wire i_client_fail,
  input wire i_unit_fail,
  input wire i_tx_valid,
  input wire i_tx_unavail,
  input wire [9:0] i_blk16_idx,
  input wire i_rx_valid,
  input wire i_rx_unavail_slot,
  input wire o_tx_ready,
  input wire o_tx_valid_ff,
  input wire [65:0] o_tx_block_ff,
  input wire o_stuff_blk,
  input wire [13:0] o_count_ff,
  input wire [23:0] o_justification_control_bytes,
  input wire o_client_fail_indicator,
  input wire o_rx_valid_ff,
  input wire [65:0] o_rx_block_ff
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  wire [9:0] b = i_blk16_idx;
  property p_pos; o_stuff_blk == (i_flexe_aware && (b == 10'h001 ||
    (o_count_ff == 14'h3b4 ? b == 10'h0ef || b == 10'h1dd || b == 10'h2cb :
    b == 10'h13e || b == 10'h27b))); endproperty
  a_pos: assert property (p_pos) else $error("stuff pos");
  property p_cnt; o_count_ff == 14'h3b4 || o_count_ff == 14'h3b5; endproperty
  a_cnt: assert property (p_cnt) else $error("count");
  property p_jc; o_justification_control_bytes[23:8] == {o_count_ff, 2'b00}; endproperty
  a_jc: assert property (p_jc) else $error("jc");
  property p_lat; i_tx_valid && o_tx_ready && !(i_flexe_aware && i_tx_unavail)
    |=> o_tx_valid_ff; endproperty
  a_lat: assert property (p_lat) else $error("tx lat");
  property p_drop; !i_client_fail [*4] ##0 i_flexe_aware && i_tx_valid && i_tx_unavail
    && o_tx_ready |=> !o_tx_valid_ff; endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_cf; i_client_fail [*4] |-> o_client_fail_indicator && o_tx_valid_ff
    && o_tx_block_ff[1:0] == 2'b10; endproperty
  a_cf: assert property (p_cf) else $error("client fail");
  property p_uf; i_unit_fail [*4] |-> o_rx_valid_ff
    && o_rx_block_ff == {56'h00000001000000, 8'h4b, 2'b10}; endproperty
  a_uf: assert property (p_uf) else $error("unit fail");
  property p_ec; !i_unit_fail [*4] ##0 i_flexe_aware && i_rx_valid && i_rx_unavail_slot
    |=> o_rx_block_ff == {{8{7'h1e}}, 8'h1e, 2'b10}; endproperty
  a_ec: assert property (p_ec) else $error("err ctrl");
endmodule
bind block_stream_payload_mapper bspm_chk chk_u (.*);
`default_nettype wire

// ===== far_loop.sv
`timescale 1ns/10ps
`default_nettype none
module far_loop (
  input wire logic i_clk,
  input wire logic i_v,
  input wire logic [65:0] i_b,
  output logic o_v,
  output logic [65:0] o_b
);
  initial begin
    o_v = 1'b0;
    o_b = 66'h0;
  end
  // idle line toggles so stale data never looks valid
  always @(negedge i_clk) begin
    o_v <= i_v;
    o_b <= i_v ? i_b : ~o_b;
  end
endmodule
`default_nettype wire

// ===== block_stream_payload_mapper_tb.sv
`timescale 1ns/10ps
`default_nettype none
module block_stream_payload_mapper_tb;
  logic clk = 0, rstn = 0, srst = 0, fa = 0, cf = 0, uf = 0, tv = 0, un = 0;
  logic fs = 0, oh = 0, ru = 0, run = 0, ck = 0, rv, txr, tov, rov;
  logic [9:0] bi = 10'h001;
  logic [9:0] pos[8] = '{10'h1, 10'hef, 10'h13e, 10'h1dd, 10'h27b, 10'h2cb, 10'h3b8, 10'h2};
  logic [13:0] cnt;
  logic [7:0] ptc = 8'h00, payload_structure_id;
  logic sb, cfi, ruen = 0;
  int n_ec = 0;
  logic [65:0] blk = 66'h0, tob, rob, rb;
  logic [65:0] q[$];
  int n_fail = 0, cmp_count = 0, j;
  initial forever #5 clk = ~clk;
  block_stream_payload_mapper #(.MAXP(4)) dut_u (.i_ref_clk(clk), .i_resetn(rstn),
    .i_sync_rst(srst), .i_flexe_aware(fa), .i_client_fail(cf), .i_unit_fail(uf),
    .i_payload_type_code(ptc), .i_num_inst(8'h02), .i_slot_cnt(20'h000b4),
    .i_inst_equipped(4'h3), .i_tx_valid(tv), .i_tx_block(blk), .i_tx_inst_sel(4'h0),
    .i_tx_is_oh(oh), .i_tx_unavail(un), .i_frame_start(fs), .i_blk16_idx(bi),
    .i_rx_valid(rv), .i_rx_block(rb), .i_rx_unavail_slot(ru), .o_tx_ready(txr),
    .o_tx_valid_ff(tov), .o_tx_block_ff(tob), .o_stuff_blk(sb), .o_stuff_data(),
    .o_count_ff(cnt), .o_justification_control_bytes(), .o_payload_structure_id(payload_structure_id),
    .o_client_fail_indicator(cfi), .o_rx_valid_ff(rov), .o_rx_block_ff(rob), .o_sh_bit_pos());
  far_loop lp_u (.i_clk(clk), .i_v(tov), .i_b(tob), .o_v(rv), .o_b(rb));
  task automatic chk(string nm, logic [65:0] s, logic [65:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("counts cmp=%0d fail=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [13:0] exp_cnt(int f);
    return ((f * 3373) % 23384 < 3373) ? 14'h3b4 : 14'h3b5;
  endfunction
  function automatic logic exp_stuff(logic [9:0] i, logic [13:0] c);
    return i == 10'h001 || ((c == 14'h3b4) ? (i == 10'hef || i == 10'h1dd || i == 10'h2cb)
      : (i == 10'h13e || i == 10'h27b));
  endfunction
  always @(negedge clk) begin
    if (txr || !tv) begin
      tv <= run && 1'($urandom);
      blk <= {$urandom, $urandom, 2'($urandom)};
      un <= fa && $urandom % 3 == 0;
      oh <= fa && $urandom % 9 == 0;
    end
    ru <= fa && run && ruen && $urandom % 4 == 0;
  end
  always @(posedge clk) if (ck && tv && txr) q.push_back(blk);
  always @(negedge clk) begin
    if (ck && rov) begin
      if (q.size() > 0) chk("loop", rob, q.pop_front());
      else chk("extra", 66'h1, 66'h0);
    end
    if (fa && run && !ruen && rov && rob == {{8{7'h1e}}, 8'h1e, 2'b10}) n_ec++;
  end
  initial begin
    void'($urandom(18));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    srst = 1;
    @(negedge clk);
    srst = 0;
    run = 1;
    ck = 1;
    repeat (200) @(negedge clk);
    run = 0;
    repeat (8) @(negedge clk);
    ck = 0;
    chk("drain", 66'(q.size()), 66'h0);
    $display("test loop done");
    ptc = 8'($urandom);
    fa = 1;
    for (j = 1; j <= 12; j++) begin
      fs = 1;
      @(negedge clk);
      fs = 0;
      foreach (pos[k]) begin
        bi = pos[k];
        #1;
        chk("stuff", 66'(sb), 66'(exp_stuff(pos[k], exp_cnt(j))));
        @(negedge clk);
      end
      chk("count", 66'(cnt), 66'(exp_cnt(j)));
    end
    fa = 0;
    chk("psi", 66'(payload_structure_id), 66'(ptc));
    $display("test sigma done");
    cf = 1;
    repeat (8) @(negedge clk);
    chk("cfi", 66'(cfi), 66'h1);
    chk("lf tx", rob, {56'h00000001000000, 8'h4b, 2'b10});
    cf = 0;
    uf = 1;
    repeat (8) @(negedge clk);
    chk("lf", rob, {56'h00000001000000, 8'h4b, 2'b10});
    uf = 0;
    $display("test fail done");
    fa = 1;
    run = 1;
    repeat (150) @(negedge clk);
    chk("pads", 66'(n_ec >= 19 + 4), 66'h1);
    ruen = 1;
    repeat (50) @(negedge clk);
    run = 0;
    $display("test flexe done");
    wrap_up;
  end
  initial begin
    #20000;
    n_fail++;
    wrap_up;
  end
endmodule
`default_nettype wire
